// >>> verilog/fram_defs.svh
/*
 * Constants of the serial ferroelectric memory slave: array geometry,
 * address byte layout, FIFO sizing and drain bound.
 * Assumes inclusion by bare name from every file that needs the values.
 */
`ifndef FRAM_DEFS_SVH
`define FRAM_DEFS_SVH

// Array geometry
`define FRAM_DATA_W 8
`define FRAM_ADDR_W 11
`define FRAM_ROW_W 8
`define FRAM_SEG_W 3
`define FRAM_DEPTH 2048

// Slave address byte layout
`define FRAM_DEV_TYPE 4'hA
`define FRAM_DEV_HI 7
`define FRAM_DEV_LO 4
`define FRAM_SEG_HI 3
`define FRAM_SEG_LO 1
`define FRAM_RW_BIT 0

// Bit counter
`define FRAM_CNT_RST 3'h0
`define FRAM_CNT_LAST 3'h7

// Write FIFO: address plus data per entry
`define FRAM_FIFO_DEPTH 8
`define FRAM_FIFO_W 19

// Most system cycles from FIFO push to array write
`define FRAM_DRAIN_MAX 3

`endif

// >>> verilog/fram_pkg.sv
/*
 * Types of the serial ferroelectric memory slave: serial state and
 * transfer phase encodings.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package fram_pkg;

   typedef enum logic [2:0] {
      ST_IDLE     = 3'b000,
      ST_RX       = 3'b001,
      ST_ACK_WAIT = 3'b010,
      ST_ACK      = 3'b011,
      ST_TX       = 3'b100,
      ST_TX_ACK   = 3'b101,
      ST_TX_NEXT  = 3'b110
   } state_type;

   typedef enum logic [1:0] {
      PH_DEV  = 2'b00,
      PH_ROW  = 2'b01,
      PH_DATA = 2'b10
   } phase_type;

endpackage

// >>> verilog/byte_fifo.sv
/*
 * Synchronous FIFO of flip-flops with valid/ready on both sides.
 * Assumes DEPTH is a power of two so the pointers wrap naturally.
 */
`timescale 1ns/1ps
module byte_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   // Clock and reset
   input wire logic i_sys_clk,
   input wire logic i_rst,
   // Fill side
   input wire logic i_in_valid,
   output logic o_in_ready,
   input wire logic [WIDTH-1:0] i_in_data,
   // Drain side
   output logic o_out_valid,
   input wire logic i_out_ready,
   output logic [WIDTH-1:0] o_out_data
);
   localparam int AW = $clog2(DEPTH);
   localparam logic [AW:0] FULL_CNT = DEPTH[AW:0];

   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [AW-1:0] wr_r, wr_nxt, rd_r, rd_nxt;
   logic [AW:0] cnt_r, cnt_nxt;
   logic push, pop;

   assign o_in_ready = (cnt_r != FULL_CNT);
   assign o_out_valid = (cnt_r != '0);
   assign o_out_data = mem_r[rd_r];
   assign push = i_in_valid & o_in_ready;
   assign pop = o_out_valid & i_out_ready;

   always_comb begin
      wr_nxt = push ? wr_r + 1'b1 : wr_r;
      rd_nxt = pop ? rd_r + 1'b1 : rd_r;
      cnt_nxt = cnt_r;
      if (push && !pop) begin
         cnt_nxt = cnt_r + 1'b1;
      end else if (pop && !push) begin
         cnt_nxt = cnt_r - 1'b1;
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_rst) begin
         wr_r <= '0;
         rd_r <= '0;
         cnt_r <= '0;
      end else begin
         wr_r <= wr_nxt;
         rd_r <= rd_nxt;
         cnt_r <= cnt_nxt;
      end
   end

   // Storage needs no reset; count gates every read
   always_ff @(posedge i_sys_clk) begin
      if (push) begin
         mem_r[wr_r] <= i_in_data;
      end
   end

endmodule

// >>> verilog/i2c_fram_slave.sv
/*
 * Two-wire serial slave in front of a 2048 x 8 byte array, oversampling
 * the serial clock and data with the system clock.
 * Assumes a bus master drives the serial clock, an external pull-up on
 * the data wire, and a system clock far faster than the serial clock.
 */
`timescale 1ns/1ps
`include "fram_defs.svh"

// Overview of operation
// - Array of 2048 bytes behind serial bus
// - Row byte selects one of 256 rows
// - Segment bits plus row form byte address
// - Bytes move bit by bit, MSB first
// - Sample on clock rise, drive on fall
// - Data pin is open drain only
// - Protect pin high blocks every array write
// - Protect pin low allows all writes
// - Unconnected protect pin reads as low only in reset
// - Each received byte written without delay
// - Write done before next transaction starts
// - Works with serial clock to 1 MHz
// - Also works at 100 and 400 kHz
// - Only a simple power-on reset
// - Slave address: type, segment, read flag
// - Address advances per byte, wraps to zero
// - Reads use latched row, new segment
// - Write after eighth bit, before acknowledge
module i2c_fram_slave (
   // Clock and power-on reset
   input wire logic i_sys_clk,
   input wire logic i_rst,
   // Serial bus
   input wire logic i_scl,
   input wire logic i_sda_in,
   output logic o_sda_out,
   output logic o_sda_oe,
   // Write protect
   input wire logic i_wp
);
   import fram_pkg::*;

   // Pin synchronisers and edge history
   logic scl_m_r, scl_s_r, scl_p_r;
   logic sda_m_r, sda_s_r, sda_p_r;
   logic wp_m_r, wp_s_r;
   logic scl_rise, scl_fall, start_det, stop_det;

   // Serial engine
   state_type state_r, state_nxt;
   phase_type phase_r, phase_nxt;
   logic [2:0] cnt_r, cnt_nxt;
   logic [`FRAM_DATA_W-1:0] shift_r, shift_nxt, rx_byte;
   logic [`FRAM_ADDR_W-1:0] addr_r, addr_nxt, rd_idx;
   logic [`FRAM_SEG_W-1:0] seg_r, seg_nxt;
   logic rw_r, rw_nxt, ack_r, ack_nxt, oe_r, oe_nxt;
   logic push, fetch;

   // Array and write path
   logic [`FRAM_DATA_W-1:0] mem_r [`FRAM_DEPTH];
   logic fifo_in_ready, fifo_out_valid, fifo_out_ready, mem_we;
   logic [`FRAM_FIFO_W-1:0] fifo_out_data;
   logic [`FRAM_ADDR_W-1:0] wr_idx;

   // Only the second stage feeds logic; the third is edge history
   always_ff @(posedge i_sys_clk) begin
      if (i_rst) begin
         scl_m_r <= 1'h1;
         scl_s_r <= 1'h1;
         scl_p_r <= 1'h1;
         sda_m_r <= 1'h1;
         sda_s_r <= 1'h1;
         sda_p_r <= 1'h1;
         wp_m_r <= 1'h0;
         wp_s_r <= 1'h0;
      end else begin
         scl_m_r <= i_scl;
         scl_s_r <= scl_m_r;
         scl_p_r <= scl_s_r;
         sda_m_r <= i_sda_in;
         sda_s_r <= sda_m_r;
         sda_p_r <= sda_s_r;
         wp_m_r <= i_wp;
         wp_s_r <= wp_m_r;
      end
   end

   // Oversampling keeps 1 MHz and the legacy rates alike
   assign scl_rise = scl_s_r & ~scl_p_r;
   assign scl_fall = ~scl_s_r & scl_p_r;
   assign start_det = scl_s_r & scl_p_r & sda_p_r & ~sda_s_r;
   assign stop_det = scl_s_r & scl_p_r & ~sda_p_r & sda_s_r;
   assign rx_byte = {shift_r[`FRAM_DATA_W-2:0], sda_s_r};
   assign rd_idx = (state_r == ST_ACK) ? {seg_r, addr_r[`FRAM_ROW_W-1:0]} : addr_r;

   always_comb begin
      state_nxt = state_r;
      phase_nxt = phase_r;
      cnt_nxt = cnt_r;
      shift_nxt = shift_r;
      addr_nxt = addr_r;
      seg_nxt = seg_r;
      rw_nxt = rw_r;
      ack_nxt = ack_r;
      oe_nxt = oe_r;
      push = 1'h0;
      fetch = 1'h0;
      if (start_det) begin
         state_nxt = ST_RX;
         phase_nxt = PH_DEV;
         cnt_nxt = `FRAM_CNT_RST;
         oe_nxt = 1'h0;
      end else if (stop_det) begin
         state_nxt = ST_IDLE;
         oe_nxt = 1'h0;
      end else begin
         unique case (state_r)
            ST_IDLE: begin
            end
            ST_RX: begin
               if (scl_rise) begin
                  shift_nxt = rx_byte;
                  cnt_nxt = cnt_r + 1'h1;
                  if (cnt_r == `FRAM_CNT_LAST) begin
                     state_nxt = ST_ACK_WAIT;
                     ack_nxt = 1'h1;
                     unique case (phase_r)
                        PH_DEV: begin
                           // Foreign address leaves the segment latch alone
                           if (rx_byte[`FRAM_DEV_HI:`FRAM_DEV_LO] != `FRAM_DEV_TYPE) begin
                              ack_nxt = 1'h0;
                           end else begin
                              seg_nxt = rx_byte[`FRAM_SEG_HI:`FRAM_SEG_LO];
                              rw_nxt = rx_byte[`FRAM_RW_BIT];
                           end
                        end
                        PH_ROW: begin
                           addr_nxt = {seg_r, rx_byte};
                        end
                        PH_DATA: begin
                           // Write queued at eighth bit, ack refused if queue full
                           push = 1'h1;
                           ack_nxt = fifo_in_ready;
                           if (fifo_in_ready) begin
                              addr_nxt = addr_r + 1'h1;
                           end
                        end
                        default: begin
                           ack_nxt = 1'h0;
                        end
                     endcase
                  end
               end
            end
            ST_ACK_WAIT: begin
               if (scl_fall) begin
                  state_nxt = ack_r ? ST_ACK : ST_IDLE;
                  oe_nxt = ack_r;
               end
            end
            ST_ACK: begin
               if (scl_fall) begin
                  cnt_nxt = `FRAM_CNT_RST;
                  if (phase_r == PH_DEV && rw_r) begin
                     // Read keeps row latch, takes segment from address byte
                     addr_nxt = rd_idx;
                     fetch = 1'h1;
                     shift_nxt = mem_r[rd_idx];
                     oe_nxt = ~shift_nxt[`FRAM_DATA_W-1];
                     phase_nxt = PH_DATA;
                     state_nxt = ST_TX;
                  end else begin
                     oe_nxt = 1'h0;
                     phase_nxt = (phase_r == PH_DEV) ? PH_ROW : PH_DATA;
                     state_nxt = ST_RX;
                  end
               end
            end
            ST_TX: begin
               if (scl_fall) begin
                  if (cnt_r == `FRAM_CNT_LAST) begin
                     oe_nxt = 1'h0;
                     addr_nxt = addr_r + 1'h1;
                     state_nxt = ST_TX_ACK;
                  end else begin
                     cnt_nxt = cnt_r + 1'h1;
                     shift_nxt = {shift_r[`FRAM_DATA_W-2:0], 1'h0};
                     oe_nxt = ~shift_nxt[`FRAM_DATA_W-1];
                  end
               end
            end
            ST_TX_ACK: begin
               if (scl_rise) begin
                  state_nxt = sda_s_r ? ST_IDLE : ST_TX_NEXT;
               end
            end
            ST_TX_NEXT: begin
               if (scl_fall) begin
                  fetch = 1'h1;
                  shift_nxt = mem_r[addr_r];
                  oe_nxt = ~shift_nxt[`FRAM_DATA_W-1];
                  cnt_nxt = `FRAM_CNT_RST;
                  state_nxt = ST_TX;
               end
            end
            default: begin
               state_nxt = ST_IDLE;
               oe_nxt = 1'h0;
            end
         endcase
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_rst) begin
         state_r <= ST_IDLE;
         phase_r <= PH_DEV;
         cnt_r <= `FRAM_CNT_RST;
         shift_r <= '0;
         addr_r <= '0;
         seg_r <= '0;
         rw_r <= 1'h0;
         ack_r <= 1'h0;
         oe_r <= 1'h0;
      end else begin
         state_r <= state_nxt;
         phase_r <= phase_nxt;
         cnt_r <= cnt_nxt;
         shift_r <= shift_nxt;
         addr_r <= addr_nxt;
         seg_r <= seg_nxt;
         rw_r <= rw_nxt;
         ack_r <= ack_nxt;
         oe_r <= oe_nxt;
      end
   end

   // Pin only ever pulls low
   assign o_sda_oe = oe_r;
   always_ff @(posedge i_sys_clk) begin
      o_sda_out <= 1'h0;
   end

   // Drain stalls in a fetch cycle so the single read port stays free
   assign fifo_out_ready = ~fetch;
   assign mem_we = fifo_out_valid & fifo_out_ready & ~wp_s_r;
   assign wr_idx = fifo_out_data[`FRAM_FIFO_W-1:`FRAM_DATA_W];

   byte_fifo #(
      .WIDTH(`FRAM_FIFO_W),
      .DEPTH(`FRAM_FIFO_DEPTH)
   ) u_wr_fifo (
      .i_sys_clk(i_sys_clk),
      .i_rst(i_rst),
      .i_in_valid(push),
      .o_in_ready(fifo_in_ready),
      .i_in_data({addr_r, rx_byte}),
      .o_out_valid(fifo_out_valid),
      .i_out_ready(fifo_out_ready),
      .o_out_data(fifo_out_data)
   );

   // Nonvolatile array: no reset
   always_ff @(posedge i_sys_clk) begin
      if (mem_we) begin
         mem_r[wr_idx] <= fifo_out_data[`FRAM_DATA_W-1:0];
      end
   end

   localparam int DRAIN_MAX = `FRAM_DRAIN_MAX;

   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (i_rst);

   wp_block_a: assert property (
      (fifo_out_valid && fifo_out_ready && wp_s_r)
      |=> mem_r[$past(wr_idx)] == $past(mem_r[wr_idx]))
      else $error("array written while protected");

   wp_allow_a: assert property (
      (fifo_out_valid && fifo_out_ready && !wp_s_r) |-> mem_we)
      else $error("unprotected write dropped");

   write_drain_a: assert property (
      (push && fifo_in_ready) |-> ##[1:DRAIN_MAX] !fifo_out_valid || mem_we || wp_s_r)
      else $error("received byte not written promptly");

   write_before_ack_a: assert property (
      (state_r == ST_ACK_WAIT && scl_fall && ack_r && phase_r == PH_DATA) |-> !fifo_out_valid)
      else $error("write still pending at acknowledge");

   ack_drive_a: assert property (
      (state_r == ST_ACK_WAIT && scl_fall && ack_r && !start_det && !stop_det)
      |=> o_sda_oe && state_r == ST_ACK)
      else $error("acknowledge not driven on fall");

   sda_on_fall_a: assert property (
      $rose(o_sda_oe) |-> $past(scl_fall))
      else $error("data pin driven away from clock fall");

   addr_step_a: assert property (
      (state_r == ST_TX && scl_fall && cnt_r == `FRAM_CNT_LAST && !start_det && !stop_det)
      |=> addr_r == $past(addr_r) + 11'h001 && !o_sda_oe)
      else $error("address not advanced after read byte");

   start_abort_a: assert property (
      start_det |=> state_r == ST_RX && phase_r == PH_DEV && cnt_r == `FRAM_CNT_RST && !o_sda_oe)
      else $error("start did not restart transfer");

   stop_abort_a: assert property (
      stop_det |=> state_r == ST_IDLE && !o_sda_oe)
      else $error("stop did not end transfer");

   read_nack_a: assert property (
      (state_r == ST_TX_ACK && scl_rise && sda_s_r && !start_det && !stop_det)
      |=> state_r == ST_IDLE ##1 !o_sda_oe)
      else $error("read did not end on master no-acknowledge");

   write_seen_c: cover property (mem_we);
   read_seen_c: cover property (state_r == ST_TX_ACK && scl_rise && !sda_s_r);
   protect_seen_c: cover property (fifo_out_valid && fifo_out_ready && wp_s_r);
   wrap_seen_c: cover property (push && addr_r == 11'h7FF);

endmodule

// >>> dv/i2c_master_model.sv
/*
 * Behavioural serial bus master: makes the serial clock and pulls the
 * data wire through an open-drain enable, one bit per clk_bit call.
 * Assumes the bench resolves the wire with a pull-up from all enables.
 */
`timescale 1ns/1ps
module i2c_master_model #(
   parameter realtime Q = 16.0
) (
   // Resolved data wire
   input wire logic i_sda,
   // Driven lines
   output logic o_scl,
   output logic o_sda_oe
);
   // Clock stands high between frames
   initial begin
      o_scl = 1'b1;
      o_sda_oe = 1'b0;
   end

   // Each phase is two steps of Q: a 64 ns bit, four system cycles a phase
   task automatic clk_bit(input logic b, output logic r);
      #(Q);
      o_sda_oe = ~b;
      #(Q);
      o_scl = 1'b1;
      #(2 * Q);
      r = i_sda;
      o_scl = 1'b0;
   endtask

   task automatic start();
      o_sda_oe = 1'b0;
      #(Q);
      o_scl = 1'b1;
      #(2 * Q);
      o_sda_oe = 1'b1;
      #(2 * Q);
      o_scl = 1'b0;
   endtask

   task automatic stop();
      #(Q);
      o_sda_oe = 1'b1;
      #(Q);
      o_scl = 1'b1;
      #(2 * Q);
      o_sda_oe = 1'b0;
      #(4 * Q);
   endtask

   // Fewer than eight bits leaves a byte unfinished
   task automatic send_bits(input logic [7:0] d, input int n);
      logic r;
      for (int i = 7; i > 7 - n; i--) begin
         clk_bit(d[i], r);
      end
   endtask

   task automatic wbyte(input logic [7:0] d, output logic ack);
      logic r;
      send_bits(d, 8);
      clk_bit(1'b1, r);
      ack = ~r;
   endtask

   // No polling: next transfer follows at once
   task automatic rbyte(output logic [7:0] d, input logic ackm);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         clk_bit(1'b1, d[i]);
      end
      clk_bit(~ackm, r);
   endtask
endmodule

// >>> dv/i2c_fram_2kx8_slave_tb_top.sv
/*
 * Self-checking bench of the serial memory slave; its write queue is
 * exercised through the top by a burst write and read-back.
 * Assumes the master model in its own file and a pull-up on the wire.
 */
`timescale 1ns/1ps
module i2c_fram_2kx8_slave_tb_top;
   typedef struct {
      logic [2:0] seg;
      logic [7:0] row;
      logic [7:0] data;
      logic wp;
      logic [7:0] exp;
   } case_type;

   logic clk = 1'b0;
   logic rst = 1'b1;
   logic wp = 1'b0;
   logic scl;
   logic m_oe;
   logic s_out;
   logic s_oe;
   wire logic sda = (m_oe | s_oe) ? 1'b0 : 1'b1;
   int fail_count = 0;
   int compares = 0;
   logic a;
   logic [7:0] d;
   case_type rows [4];

   always #4 clk = ~clk;

   i2c_fram_slave uut (.i_sys_clk(clk), .i_rst(rst), .i_scl(scl), .i_sda_in(sda),
      .o_sda_out(s_out), .o_sda_oe(s_oe), .i_wp(wp));
   i2c_master_model mst (.i_sda(sda), .o_scl(scl), .o_sda_oe(m_oe));

   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      compares++;
      if (seen !== exp) begin
         fail_count++;
         $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic close_out();
      $display("compares %0d mismatches %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   task automatic set_addr(input logic [2:0] seg, input logic [7:0] row);
      mst.start();
      mst.wbyte({4'hA, seg, 1'b0}, a);
      chk({7'h00, a}, 8'h01);
      mst.wbyte(row, a);
      chk({7'h00, a}, 8'h01);
   endtask

   task automatic wr(input logic [2:0] seg, input logic [7:0] row, input logic [7:0] v);
      set_addr(seg, row);
      mst.wbyte(v, a);
      chk({7'h00, a}, 8'h01);
      mst.stop();
   endtask

   // Repeated start then read from the latched row
   task automatic rd(input logic [2:0] seg, input logic [7:0] row, input logic [7:0] exp);
      set_addr(seg, row);
      mst.start();
      mst.wbyte({4'hA, seg, 1'b1}, a);
      chk({7'h00, a}, 8'h01);
      mst.rbyte(d, 1'b0);
      chk(d, exp);
      mst.stop();
   endtask

   initial begin
      #200000;
      fail_count++;
      $display("ERROR at %0t: watchdog expired", $time);
      close_out();
   end

   initial begin
      rows[0] = '{3'h2, 8'h10, 8'hA5, 1'b0, 8'hA5};
      rows[1] = '{3'h2, 8'h10, 8'h3C, 1'b1, 8'hA5};
      rows[2] = '{3'h7, 8'hFF, 8'h5A, 1'b0, 8'h5A};
      rows[3] = '{3'h0, 8'h00, 8'hC3, 1'b0, 8'hC3};
      repeat (6) @(negedge clk);
      rst = 1'b0;
      chk({7'h00, s_oe}, 8'h00);
      repeat (4) @(negedge clk);
      chk({7'h00, s_out}, 8'h00);
      $display("test reset done");
      // Write then read back at once, protected rows keep old data
      foreach (rows[i]) begin
         @(negedge clk);
         wp = rows[i].wp;
         wr(rows[i].seg, rows[i].row, rows[i].data);
         @(negedge clk);
         wp = 1'b0;
         rd(rows[i].seg, rows[i].row, rows[i].exp);
      end
      $display("test table done");
      // Burst across the top address wraps to zero
      set_addr(3'h7, 8'hFF);
      mst.wbyte(8'h11, a);
      mst.wbyte(8'h22, a);
      chk({7'h00, a}, 8'h01);
      mst.stop();
      set_addr(3'h7, 8'hFF);
      mst.start();
      mst.wbyte(8'hAF, a);
      mst.rbyte(d, 1'b1);
      chk(d, 8'h11);
      mst.rbyte(d, 1'b0);
      chk(d, 8'h22);
      mst.stop();
      $display("test wrap done");
      // Read takes new segment, keeps latched row
      wr(3'h3, 8'h40, 8'h77);
      set_addr(3'h5, 8'h40);
      mst.stop();
      mst.start();
      mst.wbyte(8'hA7, a);
      mst.rbyte(d, 1'b0);
      chk(d, 8'h77);
      mst.stop();
      $display("test segment done");
      // Foreign device type is refused
      mst.start();
      mst.wbyte(8'h90, a);
      chk({7'h00, a}, 8'h00);
      mst.stop();
      // Stop rides on the seventh clock, so the eighth bit never comes
      set_addr(3'h3, 8'h40);
      mst.send_bits(8'h00, 6);
      mst.stop();
      rd(3'h3, 8'h40, 8'h77);
      $display("test abort done");
      // Eight-byte burst runs every entry of the write queue
      set_addr(3'h1, 8'hF8);
      for (int i = 0; i < 8; i++) begin
         mst.wbyte(8'h10 + 8'(i), a);
         chk({7'h00, a}, 8'h01);
      end
      mst.stop();
      chk({7'h00, uut.fifo_out_valid}, 8'h00);
      set_addr(3'h1, 8'hF8);
      mst.start();
      mst.wbyte(8'hA3, a);
      chk({7'h00, a}, 8'h01);
      for (int i = 0; i < 8; i++) begin
         mst.rbyte(d, (i < 7) ? 1'b1 : 1'b0);
         chk(d, 8'h10 + 8'(i));
      end
      mst.stop();
      chk({7'h00, s_oe}, 8'h00);
      $display("test burst done");
      close_out();
   end
endmodule
